// ==== hdl/rsc_pkg.sv ====
// Constants, register map and codes for the reset strap capture block
package rsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RST_NS = 160;
  localparam int SOFT_RST_CYCLES =
    (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_CNT_W = $clog2(SOFT_RST_CYCLES + 1);

  localparam int STRAP_N = 11;
  localparam int IDX_FLOW = 0;
  localparam int IDX_LINKUP = 1;
  localparam int IDX_MGMT_LO = 2;
  localparam int IDX_MGMT_HI = 3;
  localparam int IDX_START = 4;
  localparam int IDX_P6_TYPE_LO = 5;
  localparam int IDX_P6_TYPE_HI = 6;
  localparam int IDX_P6_ROLE = 7;
  localparam int IDX_P6_SPEED = 8;
  localparam int IDX_INBAND = 9;
  localparam int IDX_CLKWIRE = 10;
  // Weak pull direction of each pin, also the value captured at reset
  localparam logic [STRAP_N-1:0] STRAP_DEFAULT = 11'h1fb;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_STRAP_LO = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STRAP_HI = 8'h01;
  localparam logic [ADDR_W-1:0] REG_P6_CTRL0 = 8'h02;
  localparam logic [ADDR_W-1:0] REG_SWITCH_OP = 8'h03;
  localparam logic [ADDR_W-1:0] REG_SOFT_RESET = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h05;
  localparam int CTRL0_CLKWIRE_BIT = 0;
  localparam int SWOP_START_BIT = 0;
  localparam int SOFTRST_GO_BIT = 0;
  localparam int STATUS_VALID_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;

  localparam logic [1:0] MGMT_MIIM = 2'h0;
  localparam logic [1:0] MGMT_I2C = 2'h1;
  localparam logic [1:0] MGMT_SPI = 2'h2;

  localparam logic [1:0] P6_GMII = 2'h3;
  localparam logic [1:0] P6_MII = 2'h2;
  localparam logic [1:0] P6_RMII = 2'h1;

  localparam logic [1:0] RXCLK_GMII_OUT = 2'h0;
  localparam logic [1:0] RXCLK_MII = 2'h1;
  localparam logic [1:0] RXCLK_REF_OUT = 2'h2;
  localparam logic [1:0] RXCLK_IDLE = 2'h3;

  typedef enum logic [2:0] {
    PH_HOLD = 3'h1,
    PH_SOFT = 3'h2,
    PH_RUN = 3'h4
  } rsc_phase_e;
endpackage

// ==== hdl/rsc_pin_sync.sv ====
// Three-flop pin synchroniser with agreement filter, one per strap pin
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_sync
  import rsc_pkg::*;
#(
  parameter int WIDTH = STRAP_N
) (
  input wire logic core_clk_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  // No reset here: the chain must keep tracking the pins while reset is
  // low, so that a clean level is ready at the release edge
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic filt_q;
      always_ff @(posedge core_clk_in) begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
      // A change counts only once the last two stages agree
      always_ff @(posedge core_clk_in) begin
        if (s2_q == s3_q) begin
          filt_q <= s3_q;
        end
      end
      assign level_out[i] = filt_q;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== hdl/rsc_clk_route.sv ====
// Port 6 receive-clock and receive-error pin role selection
`timescale 1ns/1ps
`default_nettype none
module rsc_clk_route
  import rsc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] port6_type_in,
  input wire logic port6_mac_role_in,
  input wire logic port6_rmii_clk_mode_in,
  input wire logic port6_three_wire_in,
  output logic [1:0] rx_clk_sel_out,
  output logic rx_er_mii_clk_in_out,
  output logic ref_clk_out_en_out,
  output logic ref_clk_in_en_out
);
  logic [1:0] sel_d;
  logic er_clk_d;
  logic is_rmii;

  assign is_rmii = (port6_type_in == P6_RMII);

  always_comb begin
    sel_d = RXCLK_IDLE;
    er_clk_d = 1'b0;
    if (is_rmii) begin
      sel_d = port6_rmii_clk_mode_in ? RXCLK_REF_OUT : RXCLK_IDLE;
    end else if (port6_three_wire_in && port6_mac_role_in) begin
      sel_d = RXCLK_GMII_OUT;
      er_clk_d = 1'b1;
    end else if (port6_type_in == P6_MII) begin
      // Three-wire in PHY role falls back to two-wire behaviour
      sel_d = RXCLK_MII;
    end else begin
      sel_d = RXCLK_GMII_OUT;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rx_clk_sel_out <= RXCLK_IDLE;
      rx_er_mii_clk_in_out <= 1'b0;
      ref_clk_out_en_out <= 1'b0;
      ref_clk_in_en_out <= 1'b0;
    end else begin
      rx_clk_sel_out <= sel_d;
      rx_er_mii_clk_in_out <= er_clk_d;
      ref_clk_out_en_out <= is_rmii && port6_rmii_clk_mode_in;
      ref_clk_in_en_out <= is_rmii && !port6_rmii_clk_mode_in;
    end
  end

  route_three_wire_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (port6_three_wire_in && port6_mac_role_in && !is_rmii)
      |=> (rx_er_mii_clk_in_out && rx_clk_sel_out == RXCLK_GMII_OUT))
    else $error("three-wire MAC routing wrong");

  route_two_wire_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!port6_three_wire_in && port6_type_in == P6_MII)
      |=> (!rx_er_mii_clk_in_out && rx_clk_sel_out == RXCLK_MII))
    else $error("two-wire MII routing wrong");
endmodule
`default_nettype wire

// ==== hdl/rsc_strap_capture.sv ====
// Strap pin sampling at reset release and device setting decode
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_capture
  import rsc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [STRAP_N-1:0] strap_pin_in,
  output logic [STRAP_N-1:0] strap_pin_out,
  output logic [STRAP_N-1:0] strap_pin_oe_out,
  output logic [STRAP_N-1:0] pad_pull_up_out,
  output logic [STRAP_N-1:0] pad_pull_en_out,
  input wire logic [STRAP_N-1:0] func_out_in,
  output logic config_valid_out,
  output logic flow_control_en_out,
  output logic autoneg_en_out,
  output logic auto_mdix_en_out,
  output logic [1:0] mgmt_if_out,
  output logic forwarding_en_out,
  output logic inband_mgmt_en_out,
  output logic [1:0] port6_type_out,
  output logic port6_mac_role_out,
  output logic port6_rmii_clk_mode_out,
  output logic port6_speed_1000_out,
  output logic port6_three_wire_out,
  output logic [1:0] port6_rx_clk_sel_out,
  output logic port6_rx_er_mii_clk_in_out,
  output logic port6_ref_clock_out_en_out,
  output logic port6_ref_clock_in_en_out
);
  localparam int SOFT_WAIT = SOFT_RST_CYCLES;

  rsc_phase_e phase_q;
  rsc_phase_e phase_d;
  logic [SOFT_CNT_W-1:0] soft_cnt_q;
  logic [STRAP_N-1:0] strap_level;
  logic [STRAP_N-1:0] captured_q;
  logic [STRAP_N-1:0] pin_out_q;
  logic oe_q;
  logic cfg_valid_q;
  logic clk_wire_q;
  logic start_bit_q;
  logic capture_pulse;
  logic soft_wr;
  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] p6_type_d;

  // Pads always carry the weak pull; the external resistor overrides it
  assign pad_pull_up_out = STRAP_DEFAULT;
  assign pad_pull_en_out = {STRAP_N{1'b1}};

  rsc_pin_sync #(
    .WIDTH(STRAP_N)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .pin_in(strap_pin_in),
    .level_out(strap_level)
  );

  // Software reset is only honoured while running, so it cannot restart
  // a sampling window that is already in progress
  assign soft_wr = reg_wr_in && (reg_addr_in == REG_SOFT_RESET)
    && reg_wdata_in[SOFTRST_GO_BIT] && (phase_q == PH_RUN);

  assign capture_pulse = reset_n_in && ((phase_q == PH_HOLD)
    || (phase_q == PH_SOFT && soft_cnt_q == '0));

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      PH_HOLD: begin
        phase_d = PH_RUN;
      end
      PH_RUN: begin
        if (soft_wr) begin
          phase_d = PH_SOFT;
        end
      end
      PH_SOFT: begin
        if (soft_cnt_q == '0) begin
          phase_d = PH_RUN;
        end
      end
      default: begin
        phase_d = PH_HOLD;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      phase_q <= PH_HOLD;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      soft_cnt_q <= '0;
    end else if (soft_wr) begin
      soft_cnt_q <= SOFT_CNT_W'(SOFT_RST_CYCLES - 1);
    end else if (soft_cnt_q != '0) begin
      soft_cnt_q <= soft_cnt_q - 1'b1;
    end
  end

  // Output enable drops in the same edge that leaves the running phase
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (phase_d == PH_RUN);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pin_out_q <= '0;
    end else begin
      pin_out_q <= func_out_in;
    end
  end

  assign strap_pin_oe_out = {STRAP_N{oe_q}};
  assign strap_pin_out = pin_out_q;

  // Captured copy ignores the pins once they carry their normal function
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      captured_q <= STRAP_DEFAULT;
    end else if (capture_pulse) begin
      captured_q <= strap_level;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cfg_valid_q <= 1'b0;
    end else if (soft_wr) begin
      cfg_valid_q <= 1'b0;
    end else if (capture_pulse) begin
      cfg_valid_q <= 1'b1;
    end
  end

  // A fresh capture overrides a software write landing in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      clk_wire_q <= STRAP_DEFAULT[IDX_CLKWIRE];
    end else if (capture_pulse) begin
      clk_wire_q <= strap_level[IDX_CLKWIRE];
    end else if (reg_wr_in && reg_addr_in == REG_P6_CTRL0) begin
      clk_wire_q <= reg_wdata_in[CTRL0_CLKWIRE_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      start_bit_q <= 1'b0;
    end else if (capture_pulse) begin
      start_bit_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == REG_SWITCH_OP) begin
      start_bit_q <= reg_wdata_in[SWOP_START_BIT];
    end
  end

  always_comb begin
    if (captured_q[IDX_P6_TYPE_HI:IDX_P6_TYPE_LO] == P6_MII) begin
      p6_type_d = P6_MII;
    end else if (captured_q[IDX_P6_TYPE_HI:IDX_P6_TYPE_LO] == P6_RMII) begin
      p6_type_d = P6_RMII;
    end else begin
      // The unused code falls back to the default interface
      p6_type_d = P6_GMII;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      flow_control_en_out <= STRAP_DEFAULT[IDX_FLOW];
      autoneg_en_out <= STRAP_DEFAULT[IDX_LINKUP];
      auto_mdix_en_out <= STRAP_DEFAULT[IDX_LINKUP];
      inband_mgmt_en_out <= STRAP_DEFAULT[IDX_INBAND];
    end else begin
      flow_control_en_out <= captured_q[IDX_FLOW];
      autoneg_en_out <= captured_q[IDX_LINKUP];
      auto_mdix_en_out <= captured_q[IDX_LINKUP];
      inband_mgmt_en_out <= captured_q[IDX_INBAND];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mgmt_if_out <= MGMT_SPI;
    end else if (captured_q[IDX_MGMT_HI]) begin
      mgmt_if_out <= MGMT_SPI;
    end else if (captured_q[IDX_MGMT_LO]) begin
      mgmt_if_out <= MGMT_I2C;
    end else begin
      mgmt_if_out <= MGMT_MIIM;
    end
  end

  // Forwarding waits for a valid configuration and stops in soft reset
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      forwarding_en_out <= 1'b0;
    end else begin
      forwarding_en_out <= cfg_valid_q && (phase_q == PH_RUN)
        && (captured_q[IDX_START] || start_bit_q);
    end
  end

  // Speed is passed through; the board keeps it legal for MII and RMII
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      port6_type_out <= P6_GMII;
      port6_mac_role_out <= !STRAP_DEFAULT[IDX_P6_ROLE];
      port6_rmii_clk_mode_out <= 1'b0;
      port6_speed_1000_out <= STRAP_DEFAULT[IDX_P6_SPEED];
    end else begin
      port6_type_out <= p6_type_d;
      port6_mac_role_out <= !captured_q[IDX_P6_ROLE];
      port6_rmii_clk_mode_out <= (p6_type_d == P6_RMII)
        && captured_q[IDX_P6_ROLE];
      port6_speed_1000_out <= captured_q[IDX_P6_SPEED];
    end
  end

  assign port6_three_wire_out = clk_wire_q;
  assign config_valid_out = cfg_valid_q;

  rsc_clk_route u_route (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .port6_type_in(port6_type_out),
    .port6_mac_role_in(port6_mac_role_out),
    .port6_rmii_clk_mode_in(port6_rmii_clk_mode_out),
    .port6_three_wire_in(clk_wire_q),
    .rx_clk_sel_out(port6_rx_clk_sel_out),
    .rx_er_mii_clk_in_out(port6_rx_er_mii_clk_in_out),
    .ref_clk_out_en_out(port6_ref_clock_out_en_out),
    .ref_clk_in_en_out(port6_ref_clock_in_en_out)
  );

  always_comb begin
    rd_d = '0;
    case (reg_addr_in)
      REG_STRAP_LO: begin
        rd_d = captured_q[DATA_W-1:0];
      end
      REG_STRAP_HI: begin
        rd_d = DATA_W'(captured_q[STRAP_N-1:DATA_W]);
      end
      REG_P6_CTRL0: begin
        rd_d[CTRL0_CLKWIRE_BIT] = clk_wire_q;
      end
      REG_SWITCH_OP: begin
        rd_d[SWOP_START_BIT] = start_bit_q;
      end
      REG_STATUS: begin
        rd_d[STATUS_VALID_BIT] = cfg_valid_q;
        rd_d[STATUS_BUSY_BIT] = (phase_q != PH_RUN);
      end
      default: begin
        rd_d = '0;
      end
    endcase
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= '0;
    end else if (reg_rd_in) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_out = rdata_q;

  soft_hiz_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    soft_wr |=> (strap_pin_oe_out == '0) [*8])
    else $error("strap pins driven during soft reset");

  capture_value_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    capture_pulse |=> captured_q == $past(strap_level))
    else $error("captured value differs from pin level");

  drive_after_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    capture_pulse |=> (strap_pin_oe_out == '1) ##1
      (strap_pin_out == $past(func_out_in)))
    else $error("strap pins not driven after capture");

  flow_decode_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    ##1 flow_control_en_out == $past(captured_q[IDX_FLOW]))
    else $error("flow control does not follow strap");

  linkup_decode_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(captured_q[IDX_LINKUP]) |=> (!autoneg_en_out && !auto_mdix_en_out))
    else $error("fast link-up not applied");

  mgmt_select_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!captured_q[IDX_MGMT_HI] && captured_q[IDX_MGMT_LO])
      |=> mgmt_if_out == MGMT_I2C)
    else $error("management select decode wrong");

  forward_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!captured_q[IDX_START] && !start_bit_q) |=> !forwarding_en_out)
    else $error("forwarding without start");

  inband_off_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !captured_q[IDX_INBAND] |=> !inband_mgmt_en_out)
    else $error("in-band management enabled by strap 0");

  clkwire_write_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (reg_wr_in && reg_addr_in == REG_P6_CTRL0 && !capture_pulse)
      |=> clk_wire_q == $past(reg_wdata_in[CTRL0_CLKWIRE_BIT]))
    else $error("clock wiring write lost");

  soft_capture_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    soft_wr |-> ##SOFT_WAIT capture_pulse)
    else $error("soft reset did not resample straps");

  hold_stable_a: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !capture_pulse |=> $stable(captured_q))
    else $error("captured straps changed without reset");
endmodule
`default_nettype wire

// ==== bench/rsc_board_pulls.sv ====
// Board strap resistors and pad wire model for the strap pins
`timescale 1ns/1ps
`default_nettype none
module rsc_board_pulls
  import rsc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [STRAP_N-1:0] pin_drive_in,
  input wire logic [STRAP_N-1:0] pin_oe_in,
  input wire logic [STRAP_N-1:0] pull_up_in,
  input wire logic [STRAP_N-1:0] pull_en_in,
  input wire logic [STRAP_N-1:0] ext_en_in,
  input wire logic [STRAP_N-1:0] ext_val_in,
  output logic [STRAP_N-1:0] pad_out
);
  // A pin with no pull at all wanders, so it never settles to a fair value
  logic [STRAP_N-1:0] float_q = '0;

  always_ff @(posedge core_clk_in) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < STRAP_N; i++) begin
      if (pin_oe_in[i]) begin
        pad_out[i] = pin_drive_in[i];
      end else if (ext_en_in[i]) begin
        pad_out[i] = ext_val_in[i];
      end else if (pull_en_in[i]) begin
        pad_out[i] = pull_up_in[i];
      end else begin
        pad_out[i] = float_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/rsc_strap_capture_test.sv ====
// Self-checking bench for strap capture, decode and register access
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_capture_test
  import rsc_pkg::*;
;
  logic core_clk_in, reset_n_in, reg_wr_in, reg_rd_in, rd_pend;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out;
  logic [STRAP_N-1:0] pin_lvl, pin_drv, pin_oe, pull_up, pull_en;
  logic [STRAP_N-1:0] func_out, ext_en, ext_val, s;
  logic valid, flow, aneg, mdix, fwd, inb, mac, rmc, spd, tw;
  logic rxer, refo, refi;
  logic [1:0] mgmt, ptype, rxsel;
  logic [18:0] cfg_q[$];
  logic [7:0] rd_q[$];
  int errors, total_checks, cyc, vcnt;

  rsc_strap_capture u_dut (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .strap_pin_in(pin_lvl), .strap_pin_out(pin_drv),
    .strap_pin_oe_out(pin_oe), .pad_pull_up_out(pull_up),
    .pad_pull_en_out(pull_en), .func_out_in(func_out),
    .config_valid_out(valid), .flow_control_en_out(flow),
    .autoneg_en_out(aneg), .auto_mdix_en_out(mdix), .mgmt_if_out(mgmt),
    .forwarding_en_out(fwd), .inband_mgmt_en_out(inb),
    .port6_type_out(ptype), .port6_mac_role_out(mac),
    .port6_rmii_clk_mode_out(rmc), .port6_speed_1000_out(spd),
    .port6_three_wire_out(tw), .port6_rx_clk_sel_out(rxsel),
    .port6_rx_er_mii_clk_in_out(rxer),
    .port6_ref_clock_out_en_out(refo), .port6_ref_clock_in_en_out(refi));

  rsc_board_pulls u_board (.core_clk_in(core_clk_in),
    .pin_drive_in(pin_drv), .pin_oe_in(pin_oe), .pull_up_in(pull_up),
    .pull_en_in(pull_en), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pad_out(pin_lvl));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Note layout: {rmii, route[4:0], decoded settings[12:0]}
  function automatic logic [18:0] exp_note(logic [10:0] v, logic st,
                                           logic wire3);
    logic [1:0] ty;
    logic rm, t3;
    ty = (v[6:5] == 2'h0) ? P6_GMII : v[6:5];
    rm = (ty == P6_RMII);
    t3 = wire3 & !v[7] & !rm;
    return {rm, (ty == P6_GMII || t3) ? RXCLK_GMII_OUT : RXCLK_MII, t3,
      rm & v[7], rm & !v[7], v[0], v[1], v[1],
      v[3] ? MGMT_SPI : {1'b0, v[2]}, v[4] | st, v[9], ty, !v[7],
      rm & v[7], v[8], wire3};
  endfunction

  task automatic bus(input logic wr, rd, input logic [7:0] a, d);
    reg_wr_in <= wr;
    reg_rd_in <= rd;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, e);
    rd_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic hw_reset(input logic [10:0] en, val);
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    ext_en <= en;
    ext_val <= val;
    func_out <= 11'($urandom);
    repeat (8) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("oe in reset", pin_oe, 0);
    cfg_q.push_back(exp_note((en & val) | (~en & STRAP_DEFAULT), 0,
      (en[10] ? val[10] : STRAP_DEFAULT[10])));
    @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("oe after reset", pin_oe, 11'h7ff);
    check("pin drive", pin_drv, func_out);
    repeat (4) @(posedge core_clk_in);
  endtask

  // Back-to-back accesses, a read-only write and unmapped places
  task automatic reg_scan(input logic [10:0] v);
    rd(REG_STRAP_LO, v[7:0]);
    rd(REG_STRAP_HI, {5'h00, v[10:8]});
    rd(REG_P6_CTRL0, {7'h00, v[10]});
    bus(1'b1, 1'b0, REG_STRAP_LO, 8'h00);
    bus(1'b1, 1'b0, 8'h0f, 8'hff);
    rd(REG_STRAP_LO, v[7:0]);
    rd(REG_STATUS, 8'h01);
    rd(8'h07, 8'h00);
    rd(REG_SOFT_RESET, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge core_clk_in);
  endtask

  always @(posedge core_clk_in) begin
    logic [18:0] n;
    if (rd_pend) check("read data", reg_rdata_out, rd_q.pop_front());
    rd_pend = reg_rd_in;
    vcnt = (valid === 1'b1) ? vcnt + 1 : 0;
    if (vcnt >= 4 && cfg_q.size() > 0) begin
      n = cfg_q.pop_front();
      check("settings", {flow, aneg, mdix, mgmt, fwd, inb, ptype, mac, rmc,
        spd, tw}, n[12:0]);
      check("clock route", {rxsel, rxer, refo, refi} & (n[18] ? 5'h03 :
        5'h1f), n[17:13] & (n[18] ? 5'h03 : 5'h1f));
    end
  end

  // Hang guard: a few thousand cycles is far beyond the whole sequence
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    reset_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    func_out = '0;
    ext_en = '0;
    ext_val = '0;
    rd_pend = 1'b0;
    void'($urandom(32'hadd2));
    hw_reset(11'h000, 11'h000);
    reg_scan(STRAP_DEFAULT);
    for (int i = 0; i < 8; i++) begin
      s = 11'($urandom);
      s[3:2] = i[1:0];
      s[6:5] = i[1:0];
      if (s[6:5] == P6_MII || s[6:5] == P6_RMII) s[8] = 1'b0;
      if (s[7] || s[6:5] == P6_RMII) s[10] = 1'b0;
      hw_reset(11'($urandom) | (s ^ STRAP_DEFAULT), s);
      reg_scan(s);
    end
    hw_reset(11'h7ff, 11'h040);
    bus(1'b1, 1'b0, REG_SWITCH_OP, 8'h01);
    bus(1'b1, 1'b0, REG_P6_CTRL0, 8'h01);
    rd(REG_SWITCH_OP, 8'h01);
    rd(REG_P6_CTRL0, 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (4) @(posedge core_clk_in);
    cfg_q.push_back(exp_note(11'h040, 1'b1, 1'b1));
    repeat (3) @(posedge core_clk_in);
    for (int i = 0; i < 20; i++) begin
      func_out <= 11'($urandom);
      ext_val <= ~ext_val;
      @(posedge core_clk_in);
    end
    cfg_q.push_back(exp_note(11'h040, 1'b1, 1'b1));
    rd(REG_STRAP_LO, 8'h40);
    ext_val <= 11'h2b5;
    bus(1'b1, 1'b0, REG_SOFT_RESET, 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge core_clk_in);
    rd(REG_STATUS, 8'h02);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge core_clk_in);
    check("oe in soft reset", pin_oe, 0);
    cfg_q.push_back(exp_note(11'h2b5, 1'b0, 1'b0));
    repeat (25) @(posedge core_clk_in);
    reg_scan(11'h2b5);
    check("queues empty", cfg_q.size() + rd_q.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
